// ==== hdl/ssdr_fifo.sv ====
`timescale 1ns/1ps
// Shift-style queue: the head always sits in entry 0, so the read data is a flop.
module ssdr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] entry     [DEPTH];
  logic [WIDTH-1:0] nextEntry [DEPTH];
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             next_outValid;
  logic             push;
  logic             pop;

  assign inReady = (count != CW'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outData = entry[0];

  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    if (g < DEPTH - 1)
    begin : g_mid
      assign nextEntry[g] = pop ? ((push && (count == CW'(g + 1))) ? inData : entry[g + 1])
                                : ((push && (count == CW'(g))) ? inData : entry[g]);
    end
    else
    begin : g_last
      assign nextEntry[g] = (push && !pop && (count == CW'(g))) ? inData : entry[g];
    end
  end

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + CW'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - CW'(1);
    end
    next_outValid = (next_count != '0);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count    <= '0;
      outValid <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
        entry[i] <= '0;
      end
    end
    else
    begin
      count    <= next_count;
      outValid <= next_outValid;
      for (int i = 0; i < DEPTH; i++)
      begin
        entry[i] <= nextEntry[i];
      end
    end
  end
endmodule

// ==== hdl/ssdr_pkg.sv ====
package ssdr_pkg;

  localparam int          CMD_W           = 32;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          SOURCES         = 8;
  localparam int          SAMPLE_W        = 16;
  localparam logic [5:0]  FRAME_BITS_CNT  = 6'h20;
  localparam logic [5:0]  COUNT_MAX       = 6'h3F;
  localparam logic [7:0]  CRC_POLY_LOW    = 8'h2F;
  localparam logic [7:0]  SEED_DEFAULT    = 8'hFF;
  localparam logic [3:0]  SEED_HIGH       = 4'hF;
  localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;
  localparam logic [3:0]  EXTRA_ZERO      = 4'h0;
  localparam logic [7:0]  CHECK_ZERO      = 8'h00;
  localparam logic [19:0] FIXED_ZERO      = 20'h00000;
  localparam logic [23:0] ERROR_PAYLOAD   = 24'hF00000;
  localparam logic [23:0] RSV_PAYLOAD     = 24'h000000;
  localparam logic [3:0]  CMD_RSV_A       = 4'h0;
  localparam logic [3:0]  CMD_RSV_B       = 4'h2;
  localparam logic [3:0]  CMD_RSV_C       = 4'h4;
  localparam logic [3:0]  CMD_RSV_D       = 4'h6;
  localparam logic [3:0]  CMD_RSV_E       = 4'hA;
  localparam logic [3:0]  CMD_RSV_F       = 4'hE;

  typedef enum {ANS_ERROR, ANS_DATA, ANS_RESERVED} ssdr_ans_t;
  typedef enum {FR_IDLE, FR_ACTIVE} ssdr_frame_t;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [19:0] fixedBits;
    logic [7:0]  check;
  } ssdr_cmd_t;

  typedef struct packed {
    logic        lead;
    logic [2:0]  sourceTag;
    logic [1:0]  basicStatus;
    logic [11:0] sensorSample;
    logic [3:0]  extraRes;
    logic [1:0]  detailStatus;
    logic [7:0]  check;
  } ssdr_data_resp_t;

  // Seed sits in the register before the first bit, so a word whose low byte is its
  // own check value leaves the register at zero.
  function automatic logic [7:0] ssdr_crc_word(input logic [31:0] word,
                                               input logic [7:0]  seed);
    logic [7:0] acc;
    logic       msb;
    acc = seed;
    for (int i = 31; i >= 0; i--)
    begin
      msb = acc[7];
      acc = {acc[6:0], word[i]};
      if (msb)
      begin
        acc = acc ^ CRC_POLY_LOW;
      end
    end
    return acc;
  endfunction

  function automatic logic ssdr_is_reserved(input logic [3:0] nib);
    return (nib == CMD_RSV_A) || (nib == CMD_RSV_B) || (nib == CMD_RSV_C) ||
           (nib == CMD_RSV_D) || (nib == CMD_RSV_E) || (nib == CMD_RSV_F);
  endfunction

endpackage

// ==== hdl/ssdr_spi_slave.sv ====
`timescale 1ns/1ps
module ssdr_spi_slave (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   sclk,
  input  wire logic                   ssN,
  input  wire logic                   mosi,
  input  wire logic [7:0][15:0]       sourceSamples,
  input  wire logic [1:0]             basicStatus,
  input  wire logic [1:0]             detailStatus,
  input  wire logic                   wideOutput,
  input  wire logic [3:0]             checkSeedNibble,
  input  wire logic                   cmdReady,
  output logic                        misoOut,
  output logic                        misoOe,
  output logic                        cmdValid,
  output logic [ssdr_pkg::CMD_W-1:0]  cmdData,
  output logic                        frameFault
);
  logic                  sclkMeta;
  logic                  sclkSync;
  logic                  sclkLast;
  logic                  ssMeta;
  logic                  ssSync;
  logic                  ssLast;
  logic                  mosiMeta;
  logic                  mosiSync;
  logic                  sclkRise;
  logic                  sclkFall;
  logic                  ssFall;
  logic                  ssRise;

  ssdr_pkg::ssdr_frame_t frameState;
  ssdr_pkg::ssdr_frame_t next_frameState;
  ssdr_pkg::ssdr_ans_t   ans;
  ssdr_pkg::ssdr_ans_t   next_ans;
  logic [2:0]            ansTag;
  logic [2:0]            next_ansTag;
  logic [5:0]            bitCount;
  logic [5:0]            next_bitCount;
  logic [31:0]           rxShift;
  logic [31:0]           next_rxShift;
  logic [31:0]           txShift;
  logic [31:0]           next_txShift;
  logic                  next_misoOut;
  logic                  next_misoOe;
  logic                  next_frameFault;
  logic                  pushValid;
  logic                  next_pushValid;
  logic [31:0]           pushData;
  logic [31:0]           next_pushData;

  logic                  fifoInReady;
  logic [7:0]            seedValue;
  logic [15:0]           pickedSample;
  logic [31:0]           txWord;
  logic [23:0]           payload;
  logic                  crcOk;
  logic                  nextBit;
  ssdr_pkg::ssdr_cmd_t   rxCmd;
  ssdr_pkg::ssdr_data_resp_t dataResp;

  // Pins from the master are foreign to mclk; the first stage is only ever read by the second.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      ssMeta   <= 1'b1;
      ssSync   <= 1'b1;
      ssLast   <= 1'b1;
      mosiMeta <= 1'b0;
      mosiSync <= 1'b0;
    end
    else
    begin
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      ssMeta   <= ssN;
      ssSync   <= ssMeta;
      ssLast   <= ssSync;
      mosiMeta <= mosi;
      mosiSync <= mosiMeta;
    end
  end

  assign sclkRise = sclkSync && !sclkLast;
  assign sclkFall = !sclkSync && sclkLast;
  assign ssFall   = !ssSync && ssLast;
  assign ssRise   = ssSync && !ssLast;

  assign seedValue    = (checkSeedNibble == ssdr_pkg::NIBBLE_ZERO) ? ssdr_pkg::SEED_DEFAULT
                        : {ssdr_pkg::SEED_HIGH, checkSeedNibble};
  assign pickedSample = sourceSamples[ansTag];
  assign rxCmd        = rxShift;
  assign crcOk        = (ssdr_pkg::ssdr_crc_word(rxShift, seedValue) == ssdr_pkg::CHECK_ZERO);
  assign nextBit      = txShift[30];

  // The answer is built from the live sample and status at select falling.
  always_comb
  begin
    dataResp              = '0;
    dataResp.lead         = 1'b1;
    dataResp.sourceTag    = ansTag;
    dataResp.basicStatus  = basicStatus;
    dataResp.sensorSample = pickedSample[15:4];
    dataResp.extraRes     = wideOutput ? pickedSample[3:0] : ssdr_pkg::EXTRA_ZERO;
    dataResp.detailStatus = detailStatus;
    case (ans)
      ssdr_pkg::ANS_DATA:     payload = dataResp[31:8];
      ssdr_pkg::ANS_RESERVED: payload = ssdr_pkg::RSV_PAYLOAD;
      default:                payload = ssdr_pkg::ERROR_PAYLOAD;
    endcase
    txWord = {payload, ssdr_pkg::ssdr_crc_word({payload, ssdr_pkg::CHECK_ZERO},
                                               seedValue)};
  end

  always_comb
  begin
    next_frameState = frameState;
    next_ans        = ans;
    next_ansTag     = ansTag;
    next_bitCount   = bitCount;
    next_rxShift    = rxShift;
    next_txShift    = txShift;
    next_misoOut    = misoOut;
    next_misoOe     = misoOe;
    next_frameFault = 1'b0;
    next_pushValid  = 1'b0;
    next_pushData   = pushData;
    case (frameState)
      ssdr_pkg::FR_IDLE:
      begin
        if (ssFall)
        begin
          next_frameState = ssdr_pkg::FR_ACTIVE;
          next_bitCount   = '0;
          next_txShift    = txWord;
          next_misoOut    = txWord[31];
          next_misoOe     = 1'b1;
        end
      end
      ssdr_pkg::FR_ACTIVE:
      begin
        if (ssRise)
        begin
          next_frameState = ssdr_pkg::FR_IDLE;
          next_misoOe     = 1'b0;
          next_misoOut    = 1'b0;
          // A full queue refuses the command so that the master sees the error answer.
          if ((bitCount != ssdr_pkg::FRAME_BITS_CNT) || !crcOk || !fifoInReady)
          begin
            next_ans        = ssdr_pkg::ANS_ERROR;
            next_frameFault = 1'b1;
          end
          else if (rxCmd.cmd[0] && (rxCmd.fixedBits == ssdr_pkg::FIXED_ZERO))
          begin
            next_ans       = ssdr_pkg::ANS_DATA;
            next_ansTag    = rxCmd.cmd[3:1];
            next_pushValid = 1'b1;
            next_pushData  = rxShift;
          end
          else if (ssdr_pkg::ssdr_is_reserved(rxCmd.cmd))
          begin
            next_ans       = ssdr_pkg::ANS_RESERVED;
            next_pushValid = 1'b1;
            next_pushData  = rxShift;
          end
          else
          begin
            next_ans = ssdr_pkg::ANS_ERROR;
          end
        end
        else if (sclkRise)
        begin
          next_rxShift = {rxShift[30:0], mosiSync};
          if (bitCount != ssdr_pkg::COUNT_MAX)
          begin
            next_bitCount = bitCount + 6'h01;
          end
        end
        else if (sclkFall && (bitCount != '0) && (bitCount < ssdr_pkg::FRAME_BITS_CNT))
        begin
          next_txShift = {txShift[30:0], 1'b0};
          next_misoOut = nextBit;
        end
      end
      default:
      begin
        next_frameState = ssdr_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      frameState <= ssdr_pkg::FR_IDLE;
      ans        <= ssdr_pkg::ANS_ERROR;
      ansTag     <= '0;
      bitCount   <= '0;
      rxShift    <= '0;
      txShift    <= '0;
      misoOut    <= 1'b0;
      misoOe     <= 1'b0;
      frameFault <= 1'b0;
      pushValid  <= 1'b0;
      pushData   <= '0;
    end
    else
    begin
      frameState <= next_frameState;
      ans        <= next_ans;
      ansTag     <= next_ansTag;
      bitCount   <= next_bitCount;
      rxShift    <= next_rxShift;
      txShift    <= next_txShift;
      misoOut    <= next_misoOut;
      misoOe     <= next_misoOe;
      frameFault <= next_frameFault;
      pushValid  <= next_pushValid;
      pushData   <= next_pushData;
    end
  end

  ssdr_fifo #(
    .WIDTH (ssdr_pkg::CMD_W),
    .DEPTH (ssdr_pkg::FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk      (mclk),
    .reset    (reset),
    .inValid  (pushValid),
    .inData   (pushData),
    .inReady  (fifoInReady),
    .outValid (cmdValid),
    .outData  (cmdData),
    .outReady (cmdReady)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_frame_start;
    (frameState == ssdr_pkg::FR_IDLE) && ssFall;
  endsequence
  sequence s_drive_msb;
    misoOe && (misoOut == txShift[31]);
  endsequence

  property p_first_bit;
    s_frame_start |=> s_drive_msb;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("MSB not driven at frame start");

  property p_data_echo;
    s_frame_start and (ans == ssdr_pkg::ANS_DATA) |=>
      txShift[31] && (txShift[30:28] == $past(ansTag));
  endproperty
  a_data_echo: assert property (p_data_echo) else $error("Data answer echo wrong");

  property p_sample;
    s_frame_start and (ans == ssdr_pkg::ANS_DATA) |=>
      txShift[25:14] == $past(pickedSample[15:4]);
  endproperty
  a_sample: assert property (p_sample) else $error("Sample not taken at select fall");

  property p_status;
    s_frame_start and (ans == ssdr_pkg::ANS_DATA) |=>
      (txShift[27:26] == $past(basicStatus)) && (txShift[9:8] == $past(detailStatus));
  endproperty
  a_status: assert property (p_status) else $error("Status fields misplaced");

  property p_extra;
    s_frame_start and (ans == ssdr_pkg::ANS_DATA) |=>
      txShift[13:10] == ($past(wideOutput) ? $past(pickedSample[3:0]) : ssdr_pkg::EXTRA_ZERO);
  endproperty
  a_extra: assert property (p_extra) else $error("Extra resolution bits wrong");

  property p_check;
    s_frame_start |=> ssdr_pkg::ssdr_crc_word(txShift, $past(seedValue)) == ssdr_pkg::CHECK_ZERO;
  endproperty
  a_check: assert property (p_check) else $error("Answer check byte wrong");

  property p_bad_check;
    (frameState == ssdr_pkg::FR_ACTIVE) && ssRise && !crcOk |=>
      (ans == ssdr_pkg::ANS_ERROR) && frameFault && !pushValid;
  endproperty
  a_bad_check: assert property (p_bad_check) else $error("Bad command not refused");

  property p_reserved;
    (frameState == ssdr_pkg::FR_ACTIVE) && ssRise && crcOk && fifoInReady &&
      (bitCount == ssdr_pkg::FRAME_BITS_CNT) && ssdr_pkg::ssdr_is_reserved(rxShift[31:28]) |=>
      (ans == ssdr_pkg::ANS_RESERVED) ##1 !misoOe;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved command not answered");

  property p_shift;
    (frameState == ssdr_pkg::FR_ACTIVE) && !ssRise && sclkFall &&
      (bitCount != '0) && (bitCount < ssdr_pkg::FRAME_BITS_CNT) |=> misoOut == $past(nextBit);
  endproperty
  a_shift: assert property (p_shift) else $error("Answer bit not shifted on falling clock");

  property p_short_frame;
    (frameState == ssdr_pkg::FR_ACTIVE) && ssRise && (bitCount != ssdr_pkg::FRAME_BITS_CNT) |=>
      (ans == ssdr_pkg::ANS_ERROR) && !misoOe;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("Wrong length frame accepted");
endmodule

// ==== tb/ssdr_spi_master.sv ====
`timescale 1ns/1ps
// Mode 0 master; the link clock stands low outside frames.
module ssdr_spi_master (
  output logic      sclk,
  output logic      ssN,
  output logic      mosi,
  input  wire logic misoOut,
  input  wire logic misoOe
);
  initial
  begin
    sclk = 1'b0;
    ssN  = 1'b1;
    mosi = 1'b0;
  end

  // A frame is n clock periods with select held low.
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx   = 32'h00000000;
    ssN  = 1'b0;
    mosi = tx[31];
    #160;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      #150;
      // Sampled late in the high phase, since the slave's synchroniser delays each bit.
      if (i < 32)
        rx[31-i] = misoOe ? misoOut : 1'bx;
      #10;
      sclk = 1'b0;
      mosi = (i < 31) ? tx[30-i] : ~mosi;
      #160;
    end
    ssN  = 1'b1;
    mosi = ~mosi;
    #320;
  endtask
endmodule

// ==== tb/tb_spi_sensor_data_request.sv ====
`timescale 1ns/1ps
module tb_spi_sensor_data_request;
  logic             mclk, reset, sclk, ssN, mosi, misoOut, misoOe;
  logic             cmdValid, frameFault, cmdReady, wideOutput;
  logic [7:0][15:0] sourceSamples;
  logic [1:0]       basicStatus, detailStatus;
  logic [3:0]       checkSeedNibble;
  logic [31:0]      cmdData, rx;
  logic [31:0]      expQ[$];
  int               n_fail, compares, faults, prevKind, popMode;
  logic [3:0]       prevNib;
  logic [3:0]       seeds [3];
  bit               skipNext;

  ssdr_spi_slave dut (.mclk(mclk), .reset(reset), .sclk(sclk), .ssN(ssN), .mosi(mosi),
    .sourceSamples(sourceSamples), .basicStatus(basicStatus), .detailStatus(detailStatus),
    .wideOutput(wideOutput), .checkSeedNibble(checkSeedNibble), .cmdReady(cmdReady),
    .misoOut(misoOut), .misoOe(misoOe), .cmdValid(cmdValid), .cmdData(cmdData),
    .frameFault(frameFault));

  ssdr_spi_master master (.sclk(sclk), .ssN(ssN), .mosi(mosi), .misoOut(misoOut),
    .misoOe(misoOe));

  always #20 mclk = ~mclk;

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [31:0] w);
    logic [7:0] r;
    logic       m;
    r = (checkSeedNibble == 4'h0) ? 8'hFF : {4'hF, checkSeedNibble};
    for (int i = 31; i >= 0; i--)
    begin
      m = r[7];
      r = {r[6:0], w[i]};
      if (m)
        r = r ^ 8'h2F;
    end
    return r;
  endfunction

  function automatic logic [31:0] seal(input logic [23:0] p);
    return {p, crc8({p, 8'h00})};
  endfunction

  function automatic logic [31:0] dataAns(input logic [3:0] c);
    logic [15:0] s;
    s = sourceSamples[c[3:1]];
    return seal({1'b1, c[3:1], basicStatus, s[15:4], wideOutput ? s[3:0] : 4'h0, detailStatus});
  endfunction

  // Request words carry the check byte in the low byte; corrupt flips its last bit.
  function automatic logic [31:0] mk(input logic [3:0] nib, input logic [19:0] fx,
                                     input logic corrupt);
    return seal({nib, fx}) ^ {31'h00000000, corrupt};
  endfunction

  task automatic scramble();
    for (int k = 0; k < 8; k++)
      sourceSamples[k] = 16'($urandom);
    basicStatus  = 2'($urandom);
    detailStatus = 2'($urandom);
    wideOutput   = 1'($urandom);
  endtask

  task automatic frame(input logic [31:0] c, input int n);
    logic [31:0] exp, mask;
    logic        fault;
    int          f0, k0;
    @(posedge mclk);
    #1;
    scramble();
    k0    = prevKind;
    exp   = (k0 == 1) ? dataAns(prevNib) : seal((k0 == 2) ? 24'h000000 : 24'hF00000);
    mask  = (n < 32) ? (32'hFFFFFFFF << (32 - n)) : 32'hFFFFFFFF;
    fault = (n != 32) || (crc8(c) != 8'h00) || (expQ.size() >= 32);
    prevNib  = c[31:28];
    prevKind = (fault || c[31:28] == 4'h8 || c[31:28] == 4'hC ||
               (c[28] && c[27:8] != 20'h00000)) ? 0 : (c[28] ? 1 : 2);
    if (prevKind != 0)
      expQ.push_back(c);
    f0 = faults;
    fork
      master.xfer(c, n, rx);
      #3000 scramble();
    join
    if (skipNext)
      skipNext = 1'b0;
    else if (k0 == 1)
      chk(((rx ^ exp) & mask) === 32'h0, "data answer");
    else if (k0 == 2)
      chk(((rx ^ exp) & mask) === 32'h0, "reserved answer");
    else
      chk(((rx ^ exp) & mask) === 32'h0, "error answer");
    chk(faults == f0 + int'(fault), "reject pulse");
  endtask

  always @(posedge mclk)
  begin
    cmdReady <= (popMode == 1) ? 1'($urandom) : (popMode == 2);
    if (frameFault === 1'b1)
      faults++;
    if (cmdValid === 1'b1 && cmdReady === 1'b1 && !reset)
    begin
      chk(expQ.size() > 0 && cmdData === expQ[0], "queued command");
      if (expQ.size() > 0)
        void'(expQ.pop_front());
    end
  end

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    cmdReady = 1'b0;
    sourceSamples = '0;
    basicStatus = 2'h0;
    detailStatus = 2'h0;
    wideOutput = 1'b0;
    checkSeedNibble = 4'h0;
    prevNib = 4'h0;
    seeds = '{4'h5, 4'hA, 4'h0};
    {n_fail, compares, faults, prevKind, popMode, skipNext} = '0;
    void'($urandom(32'hA3B6));
    repeat (12) @(posedge mclk);
    #1;
    chk(misoOe === 1'b0 && cmdValid === 1'b0 && frameFault === 1'b0, "reset outputs");
    reset = 1'b0;
    popMode = 1;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 16; k++)
      frame(mk(4'(k), 20'h00000, 1'b0), 32);
    repeat (40)
      frame(mk(4'($urandom), ($urandom_range(5, 0) == 0) ? 20'($urandom) : 20'h00000,
               ($urandom_range(5, 0) == 0)), 32);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      #1;
      checkSeedNibble = seeds[i];
      skipNext = 1'b1;
      repeat (4)
        frame(mk(4'($urandom), 20'h00000, 1'b0), 32);
    end
    for (int i = 0; i < 400 && expQ.size() > 0; i++)
      @(posedge mclk);
    popMode = 0;
    repeat (34)
      frame(mk({3'($urandom), 1'b1}, 20'h00000, 1'b0), 32);
    popMode = 2;
    for (int i = 0; i < 100 && cmdValid !== 1'b0; i++)
      @(posedge mclk);
    chk(expQ.size() == 0 && cmdValid === 1'b0, "queue drained");
    popMode = 1;
    frame(mk(4'h3, 20'h00000, 1'b0), 31);
    frame(mk(4'h5, 20'h00000, 1'b0), 33);
    frame(mk(4'h7, 20'h00000, 1'b0), 32);
    @(posedge mclk);
    #1;
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'b0;
    expQ.delete();
    prevKind = 0;
    repeat (4) @(posedge mclk);
    frame(mk(4'h9, 20'h00000, 1'b0), 32);
    frame(mk(4'hB, 20'h00000, 1'b0), 32);
    results();
  end

  initial
  begin
    #2400000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule
